// ==== core/iaas_core.sv ====
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
// Operation
// RULE1: In slave receive, set address match on own address or general call.
// RULE2: Address match flag sets only while primary format select is 0.
// RULE3: Address match clears on data access or 0 write after reading 1.
// RULE4: General call flag sets on all-zero first frame if either format select 0.
// RULE5: General call flag clears on data access or 0 write after reading 1.
// RULE6: Primary 1, second 0: general call flag sets, no address match.
// RULE7: Transmit with check enabled loads acknowledge bit from the bus.
// RULE8: Writing 0 to check enable clears the acknowledge bit.
// RULE9: Receive mode returns the acknowledge value after each data byte.
// RULE10: Acknowledge read gives bus sample if transmitting, else programmed value.
// RULE11: Software write updates returned acknowledge value whatever transmit select is.
// RULE12: Software re-programs acknowledge value after read-modify-write of status.
// RULE13: Software clears check enable before ending transmission with a stop.
// RULE14: Match and general call flags accept only a clearing 0 write.
// RULE15: Both flags and the acknowledge bit reset to 0.
module iaas_core
  import iaas_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic [4:0]  awaddr,
  input  wire logic        awvalid,
  output      logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output      logic        wready,
  // AXI4-Lite write response
  output      logic [1:0]  bresp,
  output      logic        bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [4:0]  araddr,
  input  wire logic        arvalid,
  output      logic        arready,
  output      logic [31:0] rdata,
  output      logic [1:0]  rresp,
  output      logic        rvalid,
  input  wire logic        rready,
  // Bus pins
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output      logic        sda_o,
  output      logic        sda_oe,
  // Interrupt
  output      logic        irq
);

  // Bus slave state
  logic        aw_full_r, aw_full_nxt;
  logic [4:0]  aw_addr_r, aw_addr_nxt;
  logic        w_full_r, w_full_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0]  w_strb_r, w_strb_nxt;
  logic        bvalid_r, bvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0]  rresp_r, rresp_nxt;
  // Register state
  iaas_ctrl_t  ctrl_r, ctrl_nxt;
  iaas_own_t   own_r, own_nxt;
  logic        aas_r, aas_nxt;
  logic        adz_r, adz_nxt;
  logic        aas_seen_r, aas_seen_nxt;
  logic        adz_seen_r, adz_seen_nxt;
  logic        ack_prog_r, ack_prog_nxt;
  logic        ack_smp_r, ack_smp_nxt;
  logic [7:0]  tx_data_r, tx_data_nxt;
  logic [IRQ_W-1:0] irq_sts_r, irq_sts_nxt;
  logic [IRQ_W-1:0] irq_en_r, irq_en_nxt;
  // Link state
  logic        scl_s1_r, scl_s2_r, scl_d_r;
  logic        sda_s1_r, sda_s2_r, sda_d_r;
  iaas_state_t state_r, state_nxt;
  logic [3:0]  cnt_r, cnt_nxt;
  logic [7:0]  shreg_r, shreg_nxt;
  logic [7:0]  rx_data_r, rx_data_nxt;
  logic        first_r, first_nxt;
  logic        addressed_r, addressed_nxt;
  logic        want_ack_r, want_ack_nxt;
  logic        ack_oe_r, ack_oe_nxt;
  // Decoded strobes and link events
  logic        do_wr, do_rd, wr_hit;
  logic        wr_sts, wr_ctrl, wr_own, wr_data, wr_iclr, wr_ien;
  logic        rd_sts, rd_data;
  logic        data_clr;
  logic        scl_rise, scl_fall, start_det, stop_det;
  logic [7:0]  frame;
  logic        byte_done, own_hit, gc_hit;
  logic        ev_aas, ev_adz, ev_ack;
  logic        ack_rd_val;

  // Handshake outputs
  assign awready = !aw_full_r;
  assign wready  = !w_full_r;
  assign arready = !rvalid_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;
  assign do_wr   = aw_full_r && w_full_r && !bvalid_r;
  assign do_rd   = arvalid && !rvalid_r;

  // Write decode, lane 0 carries every control bit except the second format select, which is in lane 1
  assign wr_sts  = do_wr && aw_addr_r == ADDR_STATUS && w_strb_r[0];
  assign wr_ctrl = do_wr && aw_addr_r == ADDR_CTRL && w_strb_r[0];
  assign wr_own  = do_wr && aw_addr_r == ADDR_OWN;
  assign wr_data = do_wr && aw_addr_r == ADDR_DATA && w_strb_r[0];
  assign wr_iclr = do_wr && aw_addr_r == ADDR_IRQ_CLR && w_strb_r[0];
  assign wr_ien  = do_wr && aw_addr_r == ADDR_IRQ_EN && w_strb_r[0];
  assign wr_hit  = aw_addr_r == ADDR_STATUS || aw_addr_r == ADDR_CTRL ||
                   aw_addr_r == ADDR_OWN || aw_addr_r == ADDR_DATA ||
                   aw_addr_r == ADDR_IRQ_CLR || aw_addr_r == ADDR_IRQ_EN;
  assign rd_sts  = do_rd && araddr == ADDR_STATUS;
  assign rd_data = do_rd && araddr == ADDR_DATA;

  // Data register access that retires both flags
  // RULE3: data access clear
  assign data_clr = (wr_data && ctrl_r.transmit_select) ||
                    (rd_data && !ctrl_r.transmit_select);

  // RULE10: acknowledge read source
  assign ack_rd_val = ctrl_r.transmit_select ? ack_smp_r : ack_prog_r;

  // Write channel capture and response
  always_comb begin
    aw_full_nxt = aw_full_r;
    aw_addr_nxt = aw_addr_r;
    w_full_nxt  = w_full_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    if (awvalid && !aw_full_r) begin
      aw_full_nxt = 1'b1;
      aw_addr_nxt = awaddr;
    end
    if (wvalid && !w_full_r) begin
      w_full_nxt = 1'b1;
      w_data_nxt = wdata;
      w_strb_nxt = wstrb;
    end
    if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
    if (do_wr) begin
      aw_full_nxt = 1'b0;
      w_full_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Read channel, data captured at the address handshake
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
    end
    if (do_rd) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      rdata_nxt  = 32'h0000_0000;
      case (araddr)
        ADDR_STATUS: begin
          rdata_nxt[STS_AAS_BIT] = aas_r;
          rdata_nxt[STS_ADZ_BIT] = adz_r;
          rdata_nxt[STS_ACK_BIT] = ack_rd_val;
        end
        ADDR_CTRL:    rdata_nxt[2:0] = ctrl_r;
        ADDR_OWN:     rdata_nxt[8:0] = own_r;
        ADDR_DATA:    rdata_nxt[7:0] = rx_data_r;
        ADDR_IRQ_STS: rdata_nxt[IRQ_W-1:0] = irq_sts_r;
        ADDR_IRQ_EN:  rdata_nxt[IRQ_W-1:0] = irq_en_r;
        ADDR_IRQ_CLR: rdata_nxt = 32'h0000_0000;
        default:      rresp_nxt = RESP_SLVERR;
      endcase
    end
  end

  // Software registers and status flags
  always_comb begin
    ctrl_nxt     = ctrl_r;
    own_nxt      = own_r;
    tx_data_nxt  = tx_data_r;
    irq_en_nxt   = irq_en_r;
    ack_prog_nxt = ack_prog_r;
    ack_smp_nxt  = ack_smp_r;
    aas_nxt      = aas_r;
    adz_nxt      = adz_r;
    aas_seen_nxt = aas_seen_r || (rd_sts && aas_r);
    adz_seen_nxt = adz_seen_r || (rd_sts && adz_r);
    irq_sts_nxt  = irq_sts_r;
    if (wr_ctrl) begin
      ctrl_nxt = w_data_r[2:0];
    end
    if (wr_own && w_strb_r[0]) begin
      own_nxt.own_address_bits      = w_data_r[7:1];
      own_nxt.format_select_primary = w_data_r[0];
    end
    if (wr_own && w_strb_r[1]) begin
      own_nxt.format_select_second = w_data_r[8];
    end
    if (wr_data && ctrl_r.transmit_select) begin
      tx_data_nxt = w_data_r[7:0];
    end
    if (wr_ien) begin
      irq_en_nxt = w_data_r[IRQ_W-1:0];
    end
    // RULE14: only a 0 write clears
    if (wr_sts && !w_data_r[STS_AAS_BIT] && aas_seen_r) begin
      aas_nxt = 1'b0;
    end
    if (wr_sts && !w_data_r[STS_ADZ_BIT] && adz_seen_r) begin
      adz_nxt = 1'b0;
    end
    // RULE3: address flag data clear
    if (data_clr || ctrl_r.master_mode) begin
      aas_nxt = 1'b0;
    end
    // RULE5: general call data clear
    if (data_clr || ctrl_r.master_mode) begin
      adz_nxt = 1'b0;
    end
    if (!aas_nxt) begin
      aas_seen_nxt = 1'b0;
    end
    if (!adz_nxt) begin
      adz_seen_nxt = 1'b0;
    end
    // RULE1: address match set wins
    if (ev_aas) begin
      aas_nxt = 1'b1;
    end
    // RULE4: general call set wins
    if (ev_adz) begin
      adz_nxt = 1'b1;
    end
    // RULE11: software acknowledge value
    if (wr_sts) begin
      ack_prog_nxt = w_data_r[STS_ACK_BIT];
    end
    // RULE8: check enable cleared
    if (wr_ctrl && !w_data_r[CTRL_ACKNOWLEDGE_CHECK_ENABLE_BIT]) begin
      ack_prog_nxt = 1'b0;
      ack_smp_nxt  = 1'b0;
    end
    // RULE7: load received acknowledge
    if (ev_ack && ctrl_r.transmit_select && ctrl_r.acknowledge_check_enable) begin
      ack_smp_nxt = sda_s2_r;
    end
    // Sticky interrupt causes, set wins over clear
    if (wr_iclr) begin
      irq_sts_nxt = irq_sts_r & ~w_data_r[IRQ_W-1:0];
    end
    if (ev_aas) begin
      irq_sts_nxt[IRQ_AAS_BIT] = 1'b1;
    end
    if (ev_adz) begin
      irq_sts_nxt[IRQ_ADZ_BIT] = 1'b1;
    end
    if (ev_ack && ctrl_r.transmit_select && ctrl_r.acknowledge_check_enable) begin
      irq_sts_nxt[IRQ_ACK_BIT] = 1'b1;
    end
  end

  // Level interrupt from enabled causes
  assign irq = |(irq_sts_r & irq_en_r);

  // Pin edges, read from second sync stage onward
  assign scl_rise  = scl_s2_r && !scl_d_r;
  assign scl_fall  = !scl_s2_r && scl_d_r;
  assign start_det = scl_s2_r && scl_d_r && sda_d_r && !sda_s2_r;
  assign stop_det  = scl_s2_r && scl_d_r && !sda_d_r && sda_s2_r;

  // Completed frame and its address decode
  assign frame     = {shreg_r[6:0], sda_s2_r};
  assign byte_done = state_r == ST_SHIFT && scl_rise && cnt_r == LAST_BIT;
  assign own_hit   = frame[7:1] == own_r.own_address_bits && !frame[0];
  assign gc_hit    = frame == GEN_CALL;
  // RULE2: primary format select gates match
  // RULE6: general call not recognized here while primary format select is 1
  assign ev_aas = byte_done && first_r && !ctrl_r.master_mode &&
                  !own_r.format_select_primary && (own_hit || gc_hit);
  // RULE4: either format select zero
  assign ev_adz = byte_done && first_r && !ctrl_r.master_mode && gc_hit &&
                  (!own_r.format_select_primary || !own_r.format_select_second);
  assign ev_ack = state_r == ST_ACK && scl_rise && addressed_r;

  // Open-drain acknowledge drive
  assign sda_o  = 1'b0;
  assign sda_oe = ack_oe_r;

  // Link sequencer: frames, acknowledge slot
  always_comb begin
    state_nxt     = state_r;
    cnt_nxt       = cnt_r;
    shreg_nxt     = shreg_r;
    rx_data_nxt   = rx_data_r;
    first_nxt     = first_r;
    addressed_nxt = addressed_r;
    want_ack_nxt  = want_ack_r;
    ack_oe_nxt    = ack_oe_r;
    case (state_r)
      ST_IDLE: begin
        ack_oe_nxt = 1'b0;
      end
      ST_SHIFT: begin
        if (scl_rise) begin
          shreg_nxt = frame;
          cnt_nxt   = cnt_r + 4'h1;
        end
        if (byte_done && first_r) begin
          addressed_nxt = ev_aas;
          want_ack_nxt  = ev_aas;
          state_nxt     = ev_aas ? ST_ACKW : ST_SKIP;
        end else if (byte_done) begin
          if (!ctrl_r.transmit_select) begin
            rx_data_nxt = frame;
          end
          // RULE9: programmed acknowledge returned
          want_ack_nxt = !ctrl_r.transmit_select && !ack_prog_r;
          state_nxt    = ST_ACKW;
        end
      end
      ST_ACKW: begin
        if (scl_fall) begin
          ack_oe_nxt = want_ack_r;
          state_nxt  = ST_ACK;
        end
      end
      ST_ACK: begin
        if (scl_fall) begin
          ack_oe_nxt = 1'b0;
          first_nxt  = 1'b0;
          cnt_nxt    = 4'h0;
          state_nxt  = ST_SHIFT;
        end
      end
      ST_SKIP: begin
        ack_oe_nxt = 1'b0;
      end
      default: begin
        ack_oe_nxt = 1'b0;
        state_nxt  = ST_IDLE;
      end
    endcase
    if (start_det) begin
      state_nxt     = ST_SHIFT;
      cnt_nxt       = 4'h0;
      first_nxt     = 1'b1;
      addressed_nxt = 1'b0;
      ack_oe_nxt    = 1'b0;
    end else if (stop_det) begin
      state_nxt     = ST_IDLE;
      addressed_nxt = 1'b0;
      ack_oe_nxt    = 1'b0;
    end
  end

  // All state registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r   <= 1'b0;
      aw_addr_r   <= 5'h00;
      w_full_r    <= 1'b0;
      w_data_r    <= 32'h0000_0000;
      w_strb_r    <= 4'h0;
      bvalid_r    <= 1'b0;
      bresp_r     <= RESP_OKAY;
      rvalid_r    <= 1'b0;
      rdata_r     <= 32'h0000_0000;
      rresp_r     <= RESP_OKAY;
      ctrl_r      <= CTRL_RST;
      own_r       <= OWN_RST;
      // RULE15: flags reset clear
      aas_r       <= 1'b0;
      adz_r       <= 1'b0;
      ack_prog_r  <= 1'b0;
      ack_smp_r   <= 1'b0;
      aas_seen_r  <= 1'b0;
      adz_seen_r  <= 1'b0;
      tx_data_r   <= BYTE_RST;
      irq_sts_r   <= IRQ_RST;
      irq_en_r    <= IRQ_RST;
      scl_s1_r    <= 1'b1;
      scl_s2_r    <= 1'b1;
      scl_d_r     <= 1'b1;
      sda_s1_r    <= 1'b1;
      sda_s2_r    <= 1'b1;
      sda_d_r     <= 1'b1;
      state_r     <= ST_IDLE;
      cnt_r       <= 4'h0;
      shreg_r     <= BYTE_RST;
      rx_data_r   <= BYTE_RST;
      first_r     <= 1'b0;
      addressed_r <= 1'b0;
      want_ack_r  <= 1'b0;
      ack_oe_r    <= 1'b0;
    end else begin
      aw_full_r   <= aw_full_nxt;
      aw_addr_r   <= aw_addr_nxt;
      w_full_r    <= w_full_nxt;
      w_data_r    <= w_data_nxt;
      w_strb_r    <= w_strb_nxt;
      bvalid_r    <= bvalid_nxt;
      bresp_r     <= bresp_nxt;
      rvalid_r    <= rvalid_nxt;
      rdata_r     <= rdata_nxt;
      rresp_r     <= rresp_nxt;
      ctrl_r      <= ctrl_nxt;
      own_r       <= own_nxt;
      aas_r       <= aas_nxt;
      adz_r       <= adz_nxt;
      ack_prog_r  <= ack_prog_nxt;
      ack_smp_r   <= ack_smp_nxt;
      aas_seen_r  <= aas_seen_nxt;
      adz_seen_r  <= adz_seen_nxt;
      tx_data_r   <= tx_data_nxt;
      irq_sts_r   <= irq_sts_nxt;
      irq_en_r    <= irq_en_nxt;
      scl_s1_r    <= scl_i;
      scl_s2_r    <= scl_s1_r;
      scl_d_r     <= scl_s2_r;
      sda_s1_r    <= sda_i;
      sda_s2_r    <= sda_s1_r;
      sda_d_r     <= sda_s2_r;
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      shreg_r     <= shreg_nxt;
      rx_data_r   <= rx_data_nxt;
      first_r     <= first_nxt;
      addressed_r <= addressed_nxt;
      want_ack_r  <= want_ack_nxt;
      ack_oe_r    <= ack_oe_nxt;
    end
  end

endmodule

// ==== pkg/iaas_pkg.sv ====
package iaas_pkg;
  // Register byte addresses
  localparam logic [4:0] ADDR_STATUS   = 5'h00;
  localparam logic [4:0] ADDR_CTRL     = 5'h04;
  localparam logic [4:0] ADDR_OWN      = 5'h08;
  localparam logic [4:0] ADDR_DATA     = 5'h0C;
  localparam logic [4:0] ADDR_IRQ_STS  = 5'h10;
  localparam logic [4:0] ADDR_IRQ_CLR  = 5'h14;
  localparam logic [4:0] ADDR_IRQ_EN   = 5'h18;
  // Status register bit positions
  localparam int STS_AAS_BIT = 2;
  localparam int STS_ADZ_BIT = 1;
  localparam int STS_ACK_BIT = 0;
  // Control register bit positions
  localparam int CTRL_TRS_BIT = 0;
  localparam int CTRL_ACKNOWLEDGE_CHECK_ENABLE_BIT = 1;
  localparam int CTRL_MST_BIT = 2;
  // Interrupt status bit positions
  localparam int IRQ_AAS_BIT = 0;
  localparam int IRQ_ADZ_BIT = 1;
  localparam int IRQ_ACK_BIT = 2;
  localparam int IRQ_W = 3;
  // Frame constants
  localparam logic [7:0] GEN_CALL = 8'h00;
  localparam logic [3:0] LAST_BIT = 4'h7;
  // Reset values
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [8:0] OWN_RST  = 9'h000;
  localparam logic [2:0] IRQ_RST  = 3'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Software control bits
  typedef struct packed {
    logic master_mode;
    logic acknowledge_check_enable;
    logic transmit_select;
  } iaas_ctrl_t;

  // Own address with format selects
  typedef struct packed {
    logic       format_select_second;
    logic [6:0] own_address_bits;
    logic       format_select_primary;
  } iaas_own_t;

  // Link sequencer states
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_SHIFT = 5'h02,
    ST_ACKW  = 5'h04,
    ST_ACK   = 5'h08,
    ST_SKIP  = 5'h10
  } iaas_state_t;
endpackage

// ==== testbench/iaas_monitor.sv ====
`timescale 1ns/1ps
module iaas_monitor
  import iaas_pkg::*;
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Write side
  input wire logic [4:0]  awaddr,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0]  wstrb,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  // Read side
  input wire logic [4:0]  araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  // Pin and interrupt
  input wire logic        sda_oe,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [4:0] oe_cnt_r;
  logic [4:0] oe_cnt_nxt;
  logic       wr_go;
  // Both write channels taken with no response pending
  assign wr_go = awvalid && awready && wvalid && wready && !bvalid;
  // Length of the current acknowledge drive, saturating
  always_comb begin
    oe_cnt_nxt = sda_oe ? oe_cnt_r + {4'h0, oe_cnt_r != 5'h1F} : 5'h00;
  end
  always_ff @(posedge aclk) begin
    oe_cnt_r <= aresetn ? oe_cnt_nxt : 5'h00;
  end

  property p_rst_quiet;
    $rose(aresetn) |-> !irq && !sda_oe && !bvalid && !rvalid;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs active after reset");
  // Channels land one edge after the take, the response one edge later
  property p_w_answer;
    wr_go |-> ##2 bvalid;
  endproperty
  a_w_answer: assert property (p_w_answer)
    else $error("write response late");
  property p_r_answer;
    arvalid && arready |=> rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer)
    else $error("read data late");
  // Read data retires at its handshake, no new read slips in behind it
  property p_r_busy;
    rvalid && rready |=> !rvalid;
  endproperty
  a_r_busy: assert property (p_r_busy)
    else $error("read data held after handshake");
  property p_unmapped;
    arvalid && arready && araddr > ADDR_IRQ_EN |=> rresp == RESP_SLVERR && rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not refused");
  property p_sts_wr;
    wr_go && awaddr == ADDR_IRQ_STS |-> ##2 bresp == RESP_SLVERR;
  endproperty
  a_sts_wr: assert property (p_sts_wr)
    else $error("event status write not refused");
  property p_irq_mask;
    wr_go && awaddr == ADDR_IRQ_EN && wstrb[0] && wdata[2:0] == 3'h0 |=> ##1 !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("masked interrupt still high");
  property p_oe_len;
    oe_cnt_r <= 5'h10;
  endproperty
  a_oe_len: assert property (p_oe_len)
    else $error("acknowledge drive too long");
endmodule

bind iaas_core iaas_monitor u_mon (
  .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
  .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
  .bresp(bresp), .bvalid(bvalid), .araddr(araddr), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
  .sda_oe(sda_oe), .irq(irq)
);

// ==== testbench/iaas_bus_model.sv ====
`timescale 1ns/1ps
module iaas_bus_model (
  // Wires toward the device
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda_line
);
  // Idle bus: clock high, data released
  initial begin
    scl = 1'h1;
    sda_low = 1'h0;
  end
  // Start: data falls while clock high
  task automatic start();
    sda_low = 1'h1;
    #24 scl = 1'h0;
  endtask
  // Eight bits MSB first, then the acknowledge clock
  task automatic frame(input logic [7:0] b, input logic ack_low, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #8 sda_low = !b[i];
      #16 scl = 1'h1;
      #24 scl = 1'h0;
    end
    #8 sda_low = ack_low;
    #16 scl = 1'h1;
    #12 ack = sda_line;
    #12 scl = 1'h0;
  endtask
  // Stop: data rises while clock high
  task automatic stop();
    #8 sda_low = 1'h1;
    #16 scl = 1'h1;
    #24 sda_low = 1'h0;
    #24;
  endtask
endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import iaas_pkg::*;
  typedef struct packed {
    logic [4:0]  a;
    logic [31:0] d;
    logic [1:0]  r;
  } iaas_row_t;
  // Bench signals
  logic        aclk    = 1'h0;
  logic        aresetn = 1'h0;
  logic [4:0]  awaddr  = 5'h00;
  logic        awvalid = 1'h0;
  logic [31:0] wdata   = 32'h0;
  logic        wvalid  = 1'h0;
  logic [4:0]  araddr  = 5'h00;
  logic        arvalid = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        scl_i, sda_low, sda_o, sda_oe, irq;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, d;
  wire         sda_i = !(sda_low | (sda_oe & !sda_o));
  int          fails = 0;
  int          checks_done = 0;
  int          cyc = 0;
  // Reset values of every register but the interrupt clear, then one unmapped word
  iaas_row_t   rows [7] = '{'{ADDR_STATUS, 32'h0, RESP_OKAY}, '{ADDR_CTRL, 32'h0, RESP_OKAY},
    '{ADDR_OWN, 32'h0, RESP_OKAY}, '{ADDR_DATA, 32'h0, RESP_OKAY},
    '{ADDR_IRQ_STS, 32'h0, RESP_OKAY}, '{ADDR_IRQ_EN, 32'h0, RESP_OKAY},
    '{5'h1C, 32'h0, RESP_SLVERR}};

  iaas_core dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(1'h1), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(1'h1), .scl_i(scl_i),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq)
  );
  iaas_bus_model m (.scl(scl_i), .sda_low(sda_low), .sda_line(sda_i));

  always #2.5 aclk = ~aclk;
  // Cut a hang short
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 15000) begin
      fails++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, s, e);
    end
  endtask
  // Write with both channels offered together
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    logic aw;
    logic w;
    aw = 1'h0;
    w = 1'h0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && awready) begin
        aw = 1'h1;
        awvalid <= 1'h0;
      end
      if (!w && wready) begin
        w = 1'h1;
        wvalid <= 1'h0;
      end
    end
    while (!bvalid) @(posedge aclk);
    r = bresp;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    @(posedge aclk);
    while (!arready) @(posedge aclk);
    arvalid <= 1'h0;
    @(posedge aclk);
    while (!rvalid) @(posedge aclk);
    d = rdata;
    r = rresp;
  endtask
  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
  endtask
  // One frame; the answer seen on the acknowledge clock
  task automatic fchk(input logic [7:0] b, input logic low, input logic e);
    logic k;
    m.frame(b, low, k);
    chk({31'h0, k}, {31'h0, e});
  endtask
  task automatic rst();
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
  endtask

  initial begin
    rst();
    foreach (rows[i]) begin
      rd(rows[i].a);
      chk(d, rows[i].d);
      chk({30'h0, r}, {30'h0, rows[i].r});
    end
    wr(ADDR_IRQ_STS, 32'h7);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    // own address match, data read clears
    wr(ADDR_OWN, 32'h154);
    wr(ADDR_IRQ_EN, 32'h7);
    m.start();
    fchk(8'h54, 1'h0, 1'h0);
    rchk(ADDR_STATUS, 32'h4);
    chk({31'h0, irq}, 32'h1);
    wr(ADDR_IRQ_EN, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(ADDR_IRQ_EN, 32'h7);
    chk({31'h0, irq}, 32'h1);
    fchk(8'hA5, 1'h0, 1'h0);
    rchk(ADDR_DATA, 32'hA5);
    rchk(ADDR_STATUS, 32'h0);
    wr(ADDR_IRQ_CLR, 32'h7);
    chk({31'h0, irq}, 32'h0);
    m.stop();
    // refused acknowledge, ones written to flags
    wr(ADDR_STATUS, 32'h1);
    rchk(ADDR_STATUS, 32'h1);
    m.start();
    fchk(8'h54, 1'h0, 1'h0);
    fchk(8'h3C, 1'h0, 1'h1);
    m.stop();
    rchk(ADDR_STATUS, 32'h5);
    wr(ADDR_STATUS, 32'h7);
    rchk(ADDR_STATUS, 32'h5);
    wr(ADDR_STATUS, 32'h0);
    rchk(ADDR_STATUS, 32'h0);
    m.start();
    fchk(8'h00, 1'h0, 1'h0);
    m.stop();
    rchk(ADDR_STATUS, 32'h6);
    wr(ADDR_STATUS, 32'h0);
    rchk(ADDR_STATUS, 32'h0);
    wr(ADDR_OWN, 32'h055);
    m.start();
    fchk(8'h00, 1'h0, 1'h1);
    m.stop();
    rchk(ADDR_STATUS, 32'h2);
    wr(ADDR_STATUS, 32'h0);
    m.start();
    fchk(8'h54, 1'h0, 1'h1);
    m.stop();
    rchk(ADDR_STATUS, 32'h0);
    wr(ADDR_OWN, 32'h154);
    m.start();
    fchk(8'h54, 1'h0, 1'h0);
    wr(ADDR_CTRL, 32'h3);
    fchk(8'hFF, 1'h0, 1'h1);
    rchk(ADDR_STATUS, 32'h5);
    wr(ADDR_DATA, 32'h5A);
    rchk(ADDR_STATUS, 32'h1);
    fchk(8'hFF, 1'h1, 1'h0);
    rchk(ADDR_STATUS, 32'h0);
    fchk(8'hFF, 1'h0, 1'h1);
    rchk(ADDR_STATUS, 32'h1);
    // check enable off before the stop
    wr(ADDR_CTRL, 32'h1);
    rchk(ADDR_STATUS, 32'h0);
    m.stop();
    wr(ADDR_STATUS, 32'h1);
    // Receive mode, checking kept on so the programmed value is not cleared
    wr(ADDR_CTRL, 32'h2);
    rchk(ADDR_STATUS, 32'h1);
    rst();
    rchk(ADDR_STATUS, 32'h0);
    rchk(ADDR_OWN, 32'h0);
    report_and_stop();
  end
endmodule
